/* File: src/ccm_ctrl.sv */
// Behaviour
// - Active vsync edge opens control channel
// - Vsync active edge programmable per device
// - Pixel clock edge and output polarity selectable
// - Horizontal sync output polarity programmable
// - Base mode bridges foreign packets to I2C
// - Base mode returns I2C responses as UART
// - Enable bit zero blocks peripheral access
// - Enable and mode bits select base or bypass
// - Reset leaves device in base mode
// - Come-back timeout clears enable, exits bypass
// - Start timer closes silent channel
// - Timeout is period times divider times count+1
// - Divider codes decode 16 up to 32768
// - Counter ticks per divided clock, ends at limit+1
// - Defaults divider 1024, count 0
// - Activity stops start timer, starts end timer
// - End timer restarts on activity, closes on silence
// - Channel open output high while open
`default_nettype none
module ccm_ctrl
    import ccm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Video pin and link events
    input wire logic vsync_pin,
    input wire logic host_activity,
    input wire logic come_back_expired,
    // Register port from the packet decoder
    input wire logic reg_wr,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Channel and mode state
    output logic control_channel_open,
    output ccm_mode_t mode,
    output ccm_pol_t pol
);

    // Divider code to ratio
    function automatic logic [15:0] div_of(input logic [3:0] code);
        if (code[3:2] == 2'b00) begin
            div_of = CCM_DIV_MIN;
        end else begin
            div_of = CCM_DIV_MIN << (code - CCM_DIV_BASE_CODE);
        end
    endfunction

    // Configuration registers
    ccm_tcfg_t start_cfg_r; // start timer setup
    ccm_tcfg_t end_cfg_r; // end timer setup
    logic [7:0] pol_r; // polarity bits
    logic [7:0] if_r; // interface enable and mode
    // Channel state and timer
    ccm_state_t st_r, st_nxt;
    logic [15:0] div_r, div_nxt; // divided clock prescaler
    logic [3:0] cnt_r, cnt_nxt; // divided periods seen
    logic open_r;
    ccm_mode_t mode_r;
    ccm_pol_t pol_r_out;
    logic [7:0] rdata_r;
    // Vsync synchroniser and filter
    logic vs1_r, vs2_r, vs3_r, vs_filt_r, vs_prev_r;

    // Mode decode
    wire if_en = if_r[CCM_IF_EN_BIT];
    wire if_ms = if_r[CCM_IF_MODE_BIT];
    wire dev_respond = !mode_r.bypass; // bypass blocks register writes, reads still return data
    wire wr_ok = reg_wr && dev_respond;

    // Vsync edge selection
    wire vs_rise = vs_filt_r && !vs_prev_r;
    wire vs_fall = !vs_filt_r && vs_prev_r;
    wire vs_active = pol_r[CCM_POL_VS_BIT] ? vs_rise : vs_fall;
    wire entry = (st_r == CCM_CLOSED) && vs_active;

    // Timer selection by phase
    ccm_tcfg_t tcfg;
    assign tcfg = (st_r == CCM_END) ? end_cfg_r : start_cfg_r;
    wire [15:0] div_sel = div_of(tcfg.div_code);
    wire div_tick = (div_r == div_sel - 16'h0001);
    wire expire = (st_r != CCM_CLOSED) && div_tick
        && (cnt_r == tcfg.cnt_lim);

    // Read data decode
    wire [7:0] stat_w = {4'h0, st_r == CCM_END, st_r == CCM_START,
        mode_r.bypass, open_r};
    logic [7:0] rdata_nxt;
    always_comb begin
        if (reg_addr == CCM_ADDR_START) begin
            rdata_nxt = start_cfg_r;
        end else if (reg_addr == CCM_ADDR_END) begin
            rdata_nxt = end_cfg_r;
        end else if (reg_addr == CCM_ADDR_POL) begin
            rdata_nxt = pol_r;
        end else if (reg_addr == CCM_ADDR_IF) begin
            rdata_nxt = if_r;
        end else if (reg_addr == CCM_ADDR_STAT) begin
            rdata_nxt = stat_w;
        end else begin
            rdata_nxt = 8'h00; // unmapped
        end
    end

    // Channel state machine and timer
    always_comb begin
        st_nxt = st_r;
        div_nxt = div_tick ? 16'h0000 : div_r + 16'h0001;
        cnt_nxt = div_tick ? cnt_r + 4'h1 : cnt_r;
        case (st_r)
            CCM_CLOSED: begin
                div_nxt = 16'h0000;
                cnt_nxt = 4'h0;
                if (entry) begin
                    st_nxt = CCM_START;
                end
            end
            CCM_START: begin
                if (host_activity) begin
                    st_nxt = CCM_END;
                    div_nxt = 16'h0000;
                    cnt_nxt = 4'h0;
                end else if (expire) begin
                    st_nxt = CCM_CLOSED;
                end
            end
            CCM_END: begin
                if (host_activity) begin
                    div_nxt = 16'h0000;
                    cnt_nxt = 4'h0;
                end else if (expire) begin
                    st_nxt = CCM_CLOSED;
                end
            end
            default: begin
                st_nxt = CCM_CLOSED;
            end
        endcase
    end

    // Vsync pin sampling
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Idle high, so no false edge follows reset
            vs1_r <= 1'b1;
            vs2_r <= 1'b1;
            vs3_r <= 1'b1;
            vs_filt_r <= 1'b1;
            vs_prev_r <= 1'b1;
        end else begin
            vs1_r <= vsync_pin;
            vs2_r <= vs1_r;
            vs3_r <= vs2_r;
            vs_filt_r <= (vs2_r == vs3_r) ? vs3_r : vs_filt_r;
            vs_prev_r <= vs_filt_r;
        end
    end

    // Timer and state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= CCM_CLOSED;
            div_r <= 16'h0000;
            cnt_r <= 4'h0;
            open_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            cnt_r <= cnt_nxt;
            open_r <= (st_nxt != CCM_CLOSED);
        end
    end

    // Timer configuration writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_cfg_r <= CCM_START_RST;
            end_cfg_r <= CCM_END_RST;
        end else begin
            if (wr_ok && reg_addr == CCM_ADDR_START) begin
                start_cfg_r <= reg_wdata;
            end
            if (wr_ok && reg_addr == CCM_ADDR_END) begin
                end_cfg_r <= reg_wdata;
            end
        end
    end

    // Polarity and interface writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pol_r <= CCM_POL_RST;
            if_r <= CCM_IF_RST;
        end else begin
            if (wr_ok && reg_addr == CCM_ADDR_POL) begin
                pol_r <= reg_wdata;
            end
            if (mode_r.bypass && come_back_expired) begin
                if_r[CCM_IF_EN_BIT] <= 1'b0;
            end else if (wr_ok && reg_addr == CCM_ADDR_IF) begin
                if_r <= reg_wdata;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= '0;
            pol_r_out <= '0;
            rdata_r <= 8'h00;
        end else begin
            mode_r.bypass <= if_en && !if_ms;
            mode_r.periph_en <= if_en;
            mode_r.i2c_bridge <= if_en && if_ms;
            pol_r_out.vsync_rise <= pol_r[CCM_POL_VS_BIT];
            pol_r_out.pclk_inv <= pol_r[CCM_POL_PCLK_BIT];
            pol_r_out.hsync_inv <= pol_r[CCM_POL_HS_BIT];
            rdata_r <= rdata_nxt;
        end
    end

    assign control_channel_open = open_r;
    assign mode = mode_r;
    assign pol = pol_r_out;
    assign reg_rdata = rdata_r;

    // Helper: cycles spent in the start phase
    logic [19:0] start_cyc_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_cyc_r <= 20'h00000;
        end else begin
            start_cyc_r <= (st_r == CCM_START) ?
                start_cyc_r + 20'h00001 : 20'h00000;
        end
    end
    // Start timeout length expected from the current setup
    wire [19:0] start_total = 20'(div_sel)
        * 20'({1'b0, tcfg.cnt_lim} + 5'h1);

    entry_open_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        entry |=> control_channel_open && st_r == CCM_START)
        else $error("channel did not open on active vsync edge");

    vs_edge_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        st_r == CCM_CLOSED && vs_rise && !pol_r[CCM_POL_VS_BIT]
        |=> !control_channel_open)
        else $error("channel opened on inactive vsync edge");

    pclk_pol_a: assert property (@(posedge clk)
        disable iff (!rst_n) wr_ok && reg_addr == CCM_ADDR_POL
        |=> ##1 pol.pclk_inv == $past(reg_wdata[CCM_POL_PCLK_BIT], 2))
        else $error("pixel clock polarity not applied");

    hs_pol_a: assert property (@(posedge clk)
        disable iff (!rst_n) wr_ok && reg_addr == CCM_ADDR_POL
        |=> ##1 pol.hsync_inv == $past(reg_wdata[CCM_POL_HS_BIT], 2))
        else $error("hsync polarity not applied");

    periph_off_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        !if_en |=> !mode.periph_en && !mode.i2c_bridge && !mode.bypass)
        else $error("peripheral not blocked with enable low");

    i2c_sel_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        if_en && if_ms |=> mode.i2c_bridge && mode.periph_en && !mode.bypass)
        else $error("I2C bridge not selected in base mode");

    bypass_sel_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        if_en && !if_ms |=> mode.bypass && !mode.i2c_bridge)
        else $error("bypass mode not selected");

    come_back_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        mode.bypass && come_back_expired |-> ##2 !mode.bypass)
        else $error("bypass not left on come-back timeout");

    start_len_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        st_r == CCM_START && expire && !host_activity
        |-> start_cyc_r + 20'h00001 == start_total)
        else $error("start timeout length wrong");

    start_close_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        st_r == CCM_START && expire && !host_activity
        |=> !control_channel_open)
        else $error("start timeout did not close channel");

    act_switch_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        st_r == CCM_START && host_activity |=> st_r == CCM_END)
        else $error("activity did not start end timer");

    end_restart_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        st_r == CCM_END && host_activity |=> div_r == 16'h0000
        && cnt_r == 4'h0 && control_channel_open)
        else $error("end timer not restarted");

    entry_clear_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        entry |=> div_r == 16'h0000 && cnt_r == 4'h0)
        else $error("timer not cleared on entry");

    open_cv: cover property (@(posedge clk) disable iff (!rst_n) entry);
    start_exp_cv: cover property (@(posedge clk) disable iff (!rst_n)
        st_r == CCM_START && expire && !host_activity);
    end_exp_cv: cover property (@(posedge clk) disable iff (!rst_n)
        st_r == CCM_END && expire && !host_activity);
    come_back_cv: cover property (@(posedge clk) disable iff (!rst_n)
        mode.bypass && come_back_expired);

endmodule
`default_nettype wire

/* File: src/ccm_pkg.sv */
`default_nettype none
package ccm_pkg;
    // Register indices
    localparam logic [3:0] CCM_ADDR_START = 4'h2;
    localparam logic [3:0] CCM_ADDR_END = 4'h3;
    localparam logic [3:0] CCM_ADDR_POL = 4'h4;
    localparam logic [3:0] CCM_ADDR_IF = 4'h8;
    localparam logic [3:0] CCM_ADDR_STAT = 4'hf;
    // Reset values: divider code 1010 (1024), count 0
    localparam logic [7:0] CCM_START_RST = 8'ha0;
    localparam logic [7:0] CCM_END_RST = 8'ha0;
    localparam logic [7:0] CCM_POL_RST = 8'h00;
    localparam logic [7:0] CCM_IF_RST = 8'hc0;
    // Field positions
    localparam int CCM_POL_VS_BIT = 6;
    localparam int CCM_POL_PCLK_BIT = 5;
    localparam int CCM_POL_HS_BIT = 4;
    localparam int CCM_IF_MODE_BIT = 7;
    localparam int CCM_IF_EN_BIT = 6;
    // Divider decode
    localparam logic [15:0] CCM_DIV_MIN = 16'h0010;
    localparam logic [3:0] CCM_DIV_BASE_CODE = 4'h4;
    // Timer configuration, upper nibble divider, lower count limit
    typedef struct packed {
        logic [3:0] div_code;
        logic [3:0] cnt_lim;
    } ccm_tcfg_t;
    // Mode outputs
    typedef struct packed {
        logic bypass;
        logic periph_en;
        logic i2c_bridge;
    } ccm_mode_t;
    // Polarity outputs
    typedef struct packed {
        logic vsync_rise;
        logic pclk_inv;
        logic hsync_inv;
    } ccm_pol_t;
    // Control channel states
    typedef enum logic [1:0] {
        CCM_CLOSED,
        CCM_START,
        CCM_END
    } ccm_state_t;
endpackage
`default_nettype wire

/* File: testbench/ccm_host_model.sv */
`default_nettype none
module ccm_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Traffic control from the bench
    input wire logic go,
    input wire logic [7:0] gap,
    // Controller activity seen by the device
    output logic host_activity
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r; // Spacing counter
    // One activity pulse per gap+1 cycles while go is high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
            host_activity <= 1'b0;
        end else begin
            host_activity <= go && (cnt_r == gap);
            cnt_r <= (go && cnt_r != gap) ? cnt_r + 8'h01 : 8'h00;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tb_ccm_ctrl.sv */
`default_nettype none
module tb_ccm_ctrl
    import ccm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, vsync_pin = 1'b1, act_lvl = 1'b0;
    logic come_back_expired = 1'b0, reg_wr = 1'b0, go = 1'b0;
    logic host_activity, control_channel_open;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    ccm_mode_t mode;
    ccm_pol_t pol;
    int n_fail = 0, cmp_count = 0, n;
    logic [15:0] exp_t [5] = '{16'd32, 16'd32, 16'd32, 16'd64, 16'd256};
    logic [7:0] cfg_t [5] = '{8'h01, 8'h31, 8'h41, 8'h51, 8'h63};
    // Clock, 4 ns period
    always #2 clk = ~clk;
    ccm_ctrl u_ccm_ctrl (.clk(clk), .rst_n(rst_n), .vsync_pin(vsync_pin),
        .host_activity(host_activity),
        .come_back_expired(come_back_expired), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .control_channel_open(control_channel_open), .mode(mode),
        .pol(pol));
    ccm_host_model u_ccm_host_model (.clk(clk), .rst_n(rst_n), .go(go),
        .gap(8'h09), .host_activity(host_activity));
    // Verdict and end of run
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Range compare, exact when lo equals hi
    task automatic chk(input logic [15:0] got, lo, hi);
        logic ok;
        ok = (got >= lo) && (got <= hi);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: got %0h expected %0h", $time, got, lo);
        end
    endtask
    // Advance to just after a rising edge
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick(1);
        reg_wr = 1'b0;
    endtask
    // Register read, data two edges later
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr = a;
        tick(2);
        chk(reg_rdata, e, e);
    endtask
    // Give a sync edge and wait for the channel to open
    task automatic enter();
        vsync_pin = ~act_lvl;
        tick(10);
        vsync_pin = act_lvl;
        n = 0;
        while (control_channel_open !== 1'b1) begin
            tick(1);
            if (++n > 30) begin
                n_fail++;
                results();
            end
        end
    endtask
    // Open the channel and measure how long it stays open
    task automatic meas(input logic [15:0] e);
        enter();
        n = 0;
        while (control_channel_open === 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        if (n >= 2000) begin
            n_fail++;
            results();
        end
        chk(16'(n), e - 16'd1, e + 16'd1);
    endtask
    // Main sequence
    initial begin
        tick(4);
        rst_n = 1'b1;
        tick(2);
        chk(16'(mode), 16'h3, 16'h3);
        rd(CCM_ADDR_START, CCM_START_RST);
        rd(CCM_ADDR_END, CCM_END_RST);
        rd(CCM_ADDR_POL, CCM_POL_RST);
        rd(CCM_ADDR_IF, CCM_IF_RST);
        rd(CCM_ADDR_STAT, 8'h00);
        rd(4'h7, 8'h00);
        meas(16'd1024);
        for (int i = 0; i < 5; i++) begin
            wr(CCM_ADDR_START, cfg_t[i]);
            rd(CCM_ADDR_START, cfg_t[i]);
            meas(exp_t[i]);
        end
        wr(CCM_ADDR_END, 8'h00);
        enter();
        go = 1'b1;
        tick(400);
        chk(16'(control_channel_open), 16'h1, 16'h1);
        go = 1'b0;
        tick(10);
        chk(16'(control_channel_open), 16'h1, 16'h1);
        tick(20);
        chk(16'(control_channel_open), 16'h0, 16'h0);
        wr(CCM_ADDR_POL, 8'h70);
        tick(2);
        chk(16'(pol), 16'h7, 16'h7);
        act_lvl = 1'b1;
        meas(16'd256);
        wr(CCM_ADDR_IF, 8'h00);
        tick(2);
        chk(16'(mode), 16'h0, 16'h0);
        wr(CCM_ADDR_IF, 8'hc0);
        tick(2);
        chk(16'(mode), 16'h3, 16'h3);
        wr(CCM_ADDR_IF, 8'h40);
        tick(2);
        chk(16'(mode), 16'h6, 16'h6);
        wr(CCM_ADDR_START, 8'hff);
        rd(CCM_ADDR_START, 8'h63);
        meas(16'd256);
        chk(16'(mode), 16'h6, 16'h6);
        rd(CCM_ADDR_STAT, 8'h02);
        come_back_expired = 1'b1;
        tick(1);
        come_back_expired = 1'b0;
        tick(3);
        chk(16'(mode), 16'h0, 16'h0);
        rd(CCM_ADDR_IF, 8'h00);
        results();
    end
endmodule
`default_nettype wire
